/* include/fspc_pkg.sv */
// fspc_pkg: constants and carrier types of the flash self-program controller
package fspc_pkg;
  // axi4-lite register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00; // flash_ctrl_reg
  localparam logic [7:0] OFS_OPSEL = 8'h04; // flash_op_select
  localparam logic [7:0] OFS_ADDR = 8'h08; // flash_addr_high/low
  localparam logic [7:0] OFS_DATA = 8'h0C; // flash_data_port
  localparam logic [7:0] OFS_CMD = 8'h10; // command_trigger_port
  localparam logic [7:0] OFS_LOWB = 8'h14; // data_area_low_bound
  localparam logic [7:0] OFS_STAT = 8'h18; // status
  // control register bit positions
  localparam int BIT_EN = 7; // flash_op_enable
  localparam int BIT_BS = 6; // boot_source_select
  localparam int BIT_SR = 5; // soft_reset_trigger
  localparam int BIT_CF = 4; // command_fail_flag
  // command bytes
  localparam logic [7:0] CMD_FIRST = 8'h46;
  localparam logic [7:0] CMD_SECOND = 8'hB9;
  // operation codes
  localparam logic [4:0] OP_STANDBY = 5'h00;
  localparam logic [4:0] OP_READ = 5'h01;
  localparam logic [4:0] OP_PROG = 5'h02;
  localparam logic [4:0] OP_ERASE = 5'h03;
  // flash geometry
  localparam logic [12:0] FLASH_LAST = 13'h1FFF;
  localparam int PAGE_BYTES = 512;
  localparam int PAGE_BITS = 9;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'hFF;
  localparam logic [12:0] ADDR_RST = 13'h0000;
  // flash operation times and cycle counts at 50 mhz
  localparam int CLK_MHZ = 50;
  localparam int T_READ_NS = 100;
  localparam int T_PROG_US = 30;
  localparam int T_ERASE_US = 40;
  localparam int CYC_READ = (T_READ_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_PROG = T_PROG_US * CLK_MHZ;
  localparam int CYC_ERASE = T_ERASE_US * CLK_MHZ;
  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // controller states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BUSY = 3'b010,
    ST_DONE = 3'b100
  } fspc_state_e;
  // request to the flash array
  typedef struct packed {
    logic rd;
    logic wr;
    logic erase;
    logic [12:0] addr;
    logic [7:0] wdata;
  } fspc_flash_req_s;
  // registered state of the controller apart from the boot latch, strap flag and freeze length counter
  typedef struct packed {
    fspc_state_e st;
    logic en;
    logic bs;
    logic sr;
    logic cf;
    logic [4:0] opsel;
    logic [12:0] addr;
    logic [7:0] data;
    logic [12:0] lowb;
    logic armed;
    logic [15:0] cnt;
    logic [4:0] op;
    logic from_ldr;
    logic aw_ok;
    logic [7:0] awaddr;
    logic w_ok;
    logic [31:0] wdata;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } fspc_regs_s;
endpackage

/* rtl/fspc_flash_mem.sv */
// fspc_flash_mem: small flash array model with registered read data
`timescale 1ns/1ps
`default_nettype none
module fspc_flash_mem (
  input wire logic clk,
  input wire fspc_pkg::fspc_flash_req_s req,
  output logic [7:0] rdata
);
  import fspc_pkg::*;
  logic [7:0] mem [0:8191]; // flash bytes
  // registered read, byte program, page erase
  always_ff @(posedge clk) begin
    if (req.rd) begin
      rdata <= mem[req.addr];
    end
    if (req.wr) begin
      mem[req.addr] <= mem[req.addr] & req.wdata; // flash only clears bits
    end
    if (req.erase) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        mem[{req.addr[12:PAGE_BITS], PAGE_BITS'(i)}] <= 8'hFF;
      end
    end
  end
endmodule
`default_nettype wire

/* rtl/fspc_top.sv */
// fspc_top: flash self-program controller with axi4-lite register access
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - ap write en+bs+reset reboots into loader
// - loader fetches get loader start added
// - stall cpu during op; hold interrupts
// - freeze, not idle; resume next instruction
// - loader ops above data area ignored
// - app ops outside data area ignored
// - with loader, area ends below loader start
// - without loader, area ends at 0x1FFF
// - low bound register loaded from configuration
// - erase is whole 512-byte page only
// - app programs data area; loader both
// - code reads valid inside data area
// - start needs 0x46 then 0xB9, enabled
// - op codes standby/read/program/erase, others reserved
// - fail flag set on failure, cleared success
// - reset trigger pulses reset, self-clears
module fspc_top (
  input wire logic CLK,
  input wire logic RST_N,
  // axi4-lite slave
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // configuration straps
  input wire logic HW_BOOT_OPTION,
  input wire logic LDR_PRESENT,
  input wire logic [12:0] LDR_START,
  input wire logic [12:0] CFG_LOW_BOUND,
  // cpu side
  input wire logic CPU_IN_LOADER,
  input wire logic [12:0] CPU_FETCH_ADDR,
  input wire logic [12:0] CODE_READ_ADDR,
  input wire logic [7:0] IRQ_PENDING,
  output logic [12:0] FLASH_FETCH_ADDR,
  output logic [7:0] CODE_READ_DATA,
  output logic CODE_READ_VALID,
  output logic CPU_STALL,
  output logic [7:0] IRQ_HELD,
  output logic SOFT_RESET_REQ,
  output logic BOOT_FROM_LOADER
);
  import fspc_pkg::*;

  fspc_regs_s r_r; // current state
  fspc_regs_s r_nxt; // next state
  fspc_flash_req_s freq; // flash request
  logic [7:0] fl_rdata; // flash read data
  logic [12:0] area_top; // data area top
  logic [12:0] area_bot; // data area bottom
  logic wr_go; // write both halves present
  logic rd_go; // read accepted
  logic trig; // command sequence complete
  logic [7:0] wb; // low write byte
  logic addr_ok; // destination allowed
  logic op_valid; // opcode performs access
  logic boot_ldr_r; // latched boot choice
  logic strap_done_r; // low bound loaded once
  logic [15:0] stall_len_r; // cycles spent frozen so far

  // destination range check per origin
  function automatic logic dest_ok(input logic ldr, input logic [12:0] a,
                                   input logic [12:0] top, input logic [12:0] bot);
    if (ldr) begin
      dest_ok = (a <= top);
    end else begin
      dest_ok = (a >= bot) && (a <= top);
    end
  endfunction

  // data area top from configuration
  always_comb begin
    if (LDR_PRESENT) begin
      area_top = LDR_START - 13'h0001;
    end else begin
      area_top = FLASH_LAST;
    end
    area_bot = r_r.lowb;
  end

  // handshake outputs
  assign S_AXI_AWREADY = !r_r.aw_ok && !r_r.bvalid;
  assign S_AXI_WREADY = !r_r.w_ok && !r_r.bvalid;
  assign S_AXI_ARREADY = !r_r.rvalid;
  assign S_AXI_BVALID = r_r.bvalid;
  assign S_AXI_BRESP = r_r.bresp;
  assign S_AXI_RVALID = r_r.rvalid;
  assign S_AXI_RDATA = r_r.rdata;
  assign S_AXI_RRESP = r_r.rresp;

  // cpu facing outputs
  assign CPU_STALL = (r_r.st != ST_IDLE);
  assign IRQ_HELD = CPU_STALL ? IRQ_PENDING : 8'h00;
  assign SOFT_RESET_REQ = r_r.sr;
  assign BOOT_FROM_LOADER = boot_ldr_r;
  assign FLASH_FETCH_ADDR = CPU_IN_LOADER ? (CPU_FETCH_ADDR + LDR_START) : CPU_FETCH_ADDR;
  assign CODE_READ_DATA = fl_rdata;
  assign CODE_READ_VALID = (CODE_READ_ADDR >= area_bot) && (CODE_READ_ADDR <= area_top);

  assign wr_go = (r_r.aw_ok || S_AXI_AWVALID) && (r_r.w_ok || S_AXI_WVALID) && !r_r.bvalid;
  assign rd_go = S_AXI_ARVALID && S_AXI_ARREADY;
  assign wb = r_r.w_ok ? r_r.wdata[7:0] : S_AXI_WDATA[7:0];

  // next-state logic
  always_comb begin
    logic [7:0] wa;
    logic [7:0] ra;
    wa = r_r.aw_ok ? r_r.awaddr : S_AXI_AWADDR;
    ra = S_AXI_ARADDR;
    r_nxt = r_r;
    trig = 1'b0;
    freq = '0;
    r_nxt.sr = 1'b0;
    op_valid = (r_r.opsel == OP_READ) || (r_r.opsel == OP_PROG) ||
               (r_r.opsel == OP_ERASE);
    addr_ok = dest_ok(CPU_IN_LOADER, r_r.addr, area_top, area_bot);
    // write channel capture
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      r_nxt.aw_ok = 1'b1;
      r_nxt.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      r_nxt.w_ok = 1'b1;
      r_nxt.wdata = S_AXI_WDATA;
    end
    // write decode
    if (wr_go) begin
      r_nxt.aw_ok = 1'b0;
      r_nxt.w_ok = 1'b0;
      r_nxt.bvalid = 1'b1;
      r_nxt.bresp = RESP_OKAY;
      if (wa == OFS_CTRL) begin
        r_nxt.en = wb[BIT_EN];
        r_nxt.bs = wb[BIT_BS];
        r_nxt.sr = wb[BIT_SR];
        r_nxt.cf = wb[BIT_CF];
      end else if (wa == OFS_OPSEL) begin
        r_nxt.opsel = wb[4:0];
      end else if (wa == OFS_ADDR) begin
        r_nxt.addr = r_r.w_ok ? r_r.wdata[12:0] : S_AXI_WDATA[12:0];
      end else if (wa == OFS_DATA) begin
        r_nxt.data = wb;
      end else if (wa == OFS_CMD) begin
        if (r_r.armed && wb == CMD_SECOND && r_r.en) begin
          trig = 1'b1;
          r_nxt.armed = 1'b0;
        end else begin
          r_nxt.armed = (wb == CMD_FIRST);
        end
      end else if (wa == OFS_LOWB) begin
        r_nxt.lowb = r_r.w_ok ? r_r.wdata[12:0] : S_AXI_WDATA[12:0];
      end else begin
        r_nxt.bresp = RESP_SLVERR;
      end
    end
    if (r_r.bvalid && S_AXI_BREADY) begin
      r_nxt.bvalid = 1'b0;
    end
    // read decode
    if (rd_go) begin
      r_nxt.rvalid = 1'b1;
      r_nxt.rresp = RESP_OKAY;
      r_nxt.rdata = 32'h0000_0000;
      if (ra == OFS_CTRL) begin
        r_nxt.rdata[7:0] = {r_r.en, r_r.bs, r_r.sr, r_r.cf, 4'h0};
      end else if (ra == OFS_OPSEL) begin
        r_nxt.rdata[4:0] = r_r.opsel;
      end else if (ra == OFS_ADDR) begin
        r_nxt.rdata[12:0] = r_r.addr;
      end else if (ra == OFS_DATA) begin
        r_nxt.rdata[7:0] = r_r.data;
      end else if (ra == OFS_CMD) begin
        r_nxt.rdata = 32'h0000_0000;
      end else if (ra == OFS_LOWB) begin
        r_nxt.rdata[12:0] = r_r.lowb;
      end else if (ra == OFS_STAT) begin
        r_nxt.rdata[2:0] = {r_r.armed, CPU_STALL, CPU_IN_LOADER};
      end else begin
        r_nxt.rresp = RESP_SLVERR;
      end
    end else if (r_r.rvalid && S_AXI_RREADY) begin
      r_nxt.rvalid = 1'b0;
    end
    // operation sequencer
    case (r_r.st)
      ST_IDLE: begin
        if (trig) begin
          if (!op_valid) begin
            r_nxt.st = ST_IDLE;
          end else if (!addr_ok) begin
            r_nxt.cf = 1'b1;
          end else begin
            r_nxt.st = ST_BUSY;
            r_nxt.op = r_r.opsel;
            r_nxt.from_ldr = CPU_IN_LOADER;
            if (r_r.opsel == OP_READ) begin
              r_nxt.cnt = 16'(CYC_READ);
            end else if (r_r.opsel == OP_PROG) begin
              r_nxt.cnt = 16'(CYC_PROG);
            end else begin
              r_nxt.cnt = 16'(CYC_ERASE);
            end
          end
        end
      end
      ST_BUSY: begin
        if (r_r.cnt <= 16'h0001) begin
          r_nxt.st = ST_DONE;
          freq.addr = r_r.addr;
          freq.wdata = r_r.data;
          freq.rd = (r_r.op == OP_READ);
          freq.wr = (r_r.op == OP_PROG);
          freq.erase = (r_r.op == OP_ERASE);
        end else begin
          r_nxt.cnt = r_r.cnt - 16'h0001;
        end
      end
      ST_DONE: begin
        if (r_r.op == OP_READ) begin
          r_nxt.data = fl_rdata;
        end
        r_nxt.cf = 1'b0;
        r_nxt.st = ST_IDLE;
      end
      default: begin
        r_nxt.st = ST_IDLE;
      end
    endcase
    // code-space reads use the array when idle
    if (r_r.st == ST_IDLE && freq == '0) begin
      freq.rd = 1'b1;
      freq.addr = CODE_READ_ADDR;
    end
  end

  // state register
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      r_r <= '{st: ST_IDLE, data: DATA_RST, addr: ADDR_RST, default: '0};
    end else begin
      r_r <= r_nxt;
      if (!strap_done_r) begin
        r_r.lowb <= CFG_LOW_BOUND;
      end
    end
  end

  // boot choice and bound load after reset release
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      strap_done_r <= 1'b0;
      boot_ldr_r <= 1'b0;
    end else begin
      strap_done_r <= 1'b1;
      if (!strap_done_r) begin
        boot_ldr_r <= HW_BOOT_OPTION && LDR_PRESENT;
      end else if (r_r.sr) begin
        boot_ldr_r <= r_r.bs && LDR_PRESENT;
      end
    end
  end

  // flash array
  fspc_flash_mem u_mem (
    .clk(CLK),
    .req(freq),
    .rdata(fl_rdata)
  );

  // reset pulse lasts one cycle and boot follows select
  property p_soft_reset_trigger;
    @(posedge CLK) disable iff (!RST_N)
      r_r.sr |=> !r_r.sr && (boot_ldr_r == ($past(r_r.bs) && LDR_PRESENT));
  endproperty
  a_soft_reset_trigger: assert property (p_soft_reset_trigger) else $error("soft reset wrong");

  // trigger with bad opcode never stalls
  property p_noop;
    @(posedge CLK) disable iff (!RST_N)
      (trig && !op_valid && r_r.st == ST_IDLE) |=> !CPU_STALL;
  endproperty
  a_noop: assert property (p_noop) else $error("reserved op stalled");

  // refused destination flags fail without stall
  property p_refuse;
    @(posedge CLK) disable iff (!RST_N)
      (trig && op_valid && !addr_ok && r_r.st == ST_IDLE) |=> r_r.cf && !CPU_STALL;
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad destination accepted");

  // good trigger stalls from the next cycle
  sequence s_start;
    trig && op_valid && addr_ok && r_r.st == ST_IDLE;
  endsequence
  property p_stall;
    @(posedge CLK) disable iff (!RST_N)
      s_start |=> CPU_STALL;
  endproperty
  a_stall: assert property (p_stall) else $error("stall wrong");

  // length of the current freeze, too long for a delay range
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      stall_len_r <= 16'h0000;
    end else if (CPU_STALL) begin
      stall_len_r <= stall_len_r + 16'h0001;
    end else begin
      stall_len_r <= 16'h0000;
    end
  end

  // freeze never outlasts the longest operation plus its done cycle
  property p_stall_len;
    @(posedge CLK) disable iff (!RST_N)
      CPU_STALL |-> stall_len_r <= 16'(CYC_ERASE);
  endproperty
  a_stall_len: assert property (p_stall_len) else $error("stall too long");

  // completion clears fail flag
  property p_done;
    @(posedge CLK) disable iff (!RST_N)
      (r_r.st == ST_DONE) |=> !r_r.cf && r_r.st == ST_IDLE;
  endproperty
  a_done: assert property (p_done) else $error("fail flag not cleared");

  // trigger requires the enable
  property p_trig_en;
    @(posedge CLK) disable iff (!RST_N)
      trig |-> r_r.en && r_r.armed;
  endproperty
  a_trig_en: assert property (p_trig_en) else $error("trigger without arm");

  // top of data area tracks loader start
  property p_top;
    @(posedge CLK) disable iff (!RST_N)
      (LDR_PRESENT && CODE_READ_ADDR >= LDR_START) |-> !CODE_READ_VALID;
  endproperty
  a_top: assert property (p_top) else $error("area top wrong");

  // held interrupts only while stalled
  property p_irq;
    @(posedge CLK) disable iff (!RST_N)
      !CPU_STALL |-> IRQ_HELD == 8'h00;
  endproperty
  a_irq: assert property (p_irq) else $error("irq held while running");
endmodule
`default_nettype wire

/* dv/fspc_cpu_model.sv */
// fspc_cpu_model: cpu-side interrupt source that keeps level requests up
`timescale 1ns/1ps
`default_nettype none
module fspc_cpu_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic stall,
  input wire logic [7:0] irq_src,
  output logic [7:0] irq_lvl
);
  // level lines follow the source, but never drop while the cpu is frozen
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_lvl <= 8'h00;
    end else if (!stall) begin
      irq_lvl <= irq_src;
    end else begin
      irq_lvl <= irq_lvl | irq_src;
    end
  end
endmodule
`default_nettype wire

/* dv/fspc_top_bench.sv */
// fspc_top_bench: register-level bench of the flash self-program controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module fspc_top_bench;
  import fspc_pkg::*;
  localparam logic [12:0] LDR = 13'h1C00; // loader start strap
  localparam logic [12:0] LOWB = 13'h1800; // configured low bound
  localparam logic [4:0] RSV [3] = '{5'h00, 5'h04, 5'h1F}; // standby and reserved
  logic clk, rst_n, awv, wv, bready, arv, rready, in_ldr, ldr_on;
  logic awr, wr, bv, arr, rv, stall, crv, srq, bfl, seen;
  logic [7:0] awaddr, araddr, irq_src, irq_lvl, crd, held;
  logic [31:0] wdata, rd, rdata;
  logic [1:0] rsp, bresp, rresp, wrsp;
  logic [12:0] fetch, cra, ffa;
  int error_cnt = 0;
  int num_checks = 0;
  int pulses = 0;
  // device under test
  fspc_top u_fspc_top (.CLK(clk), .RST_N(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready),
    .HW_BOOT_OPTION(1'b0), .LDR_PRESENT(ldr_on), .LDR_START(LDR), .CFG_LOW_BOUND(LOWB),
    .CPU_IN_LOADER(in_ldr), .CPU_FETCH_ADDR(fetch), .CODE_READ_ADDR(cra),
    .IRQ_PENDING(irq_lvl), .FLASH_FETCH_ADDR(ffa), .CODE_READ_DATA(crd),
    .CODE_READ_VALID(crv), .CPU_STALL(stall), .IRQ_HELD(held),
    .SOFT_RESET_REQ(srq), .BOOT_FROM_LOADER(bfl));
  // cpu-side partner
  fspc_cpu_model u_fspc_cpu_model (.clk(clk), .rst_n(rst_n), .stall(stall),
    .irq_src(irq_src), .irq_lvl(irq_lvl));
  // 50 mhz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // count soft reset pulse cycles
  always @(posedge clk) begin
    if (srq === 1'b1) pulses++;
  end
  // verdict and end of run
  task final_report;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // axi4-lite write: address and data offered together, held until taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
      n++;
    end while (!bv && n < 100);
    wrsp = bresp;
    bready <= 1'b0;
    `CHK(n < 100, 1'b1)
  endtask
  // axi4-lite read: data and response taken at the rvalid edge
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      n++;
    end while (!rv && n < 100);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    `CHK(n < 100, 1'b1)
  endtask
  // code-space read address, then validity two edges later
  task automatic cr(input logic [12:0] a, input logic e);
    cra <= a;
    @(posedge clk);
    @(posedge clk);
    `CHK(crv, e)
  endtask
  // full operation: setup, command bytes, optional stray byte, then wait
  task automatic op(input logic [4:0] o, input logic [12:0] a, input logic [7:0] d,
                    input logic [7:0] mid, output logic st);
    int n;
    n = 0;
    st = 1'b0;
    irq_src <= 8'h05;
    axw(OFS_OPSEL, {27'h0, o});
    axw(OFS_ADDR, {19'h0, a});
    axw(OFS_DATA, {24'h0, d});
    axw(OFS_CMD, {24'h0, CMD_FIRST});
    if (mid != 8'h00) axw(OFS_CMD, {24'h0, mid});
    axw(OFS_CMD, {24'h0, CMD_SECOND});
    repeat (3) begin
      @(posedge clk);
      if (stall === 1'b1) st = 1'b1;
    end
    if (st) begin
      irq_src <= 8'h00;
      repeat (2) @(posedge clk);
      `CHK(held, 8'h05)
    end
    while (stall === 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    `CHK(held, 8'h00)
    `CHK(n < 3000, 1'b1)
  endtask
  // hang guard, well beyond the expected run
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    final_report();
  end
  // main sequence
  initial begin
    rst_n = 1'b0;
    {awv, wv, bready, arv, rready, in_ldr} = 6'h00;
    ldr_on = 1'b1;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    fetch = 13'h0123;
    cra = 13'h0000;
    irq_src = 8'h00;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    axr(OFS_CTRL, rd, rsp);
    `CHK(rd, {24'h0, CTRL_RST})
    axr(OFS_DATA, rd, rsp);
    `CHK(rd, {24'h0, DATA_RST})
    axr(OFS_ADDR, rd, rsp);
    `CHK(rd, {19'h0, ADDR_RST})
    axr(OFS_LOWB, rd, rsp);
    `CHK(rd, {19'h0, LOWB})
    axr(8'h1C, rd, rsp);
    `CHK(rsp, RESP_SLVERR)
    `CHK(bfl, 1'b0)
    axw(8'h1C, 32'h0000_0000);
    `CHK(wrsp, RESP_SLVERR)
    $display("test registers done");
    in_ldr <= 1'b1;
    cr(LDR - 13'h1, 1'b1);
    `CHK(ffa, 13'h0123 + LDR)
    axr(OFS_STAT, rd, rsp);
    `CHK(rd, 32'h0000_0001)
    in_ldr <= 1'b0;
    cr(LDR, 1'b0);
    `CHK(ffa, 13'h0123)
    cr(LOWB - 13'h1, 1'b0);
    ldr_on <= 1'b0;
    cr(FLASH_LAST, 1'b1);
    ldr_on <= 1'b1;
    $display("test boundaries done");
    axw(OFS_CTRL, 32'h80);
    `CHK(wrsp, RESP_OKAY)
    op(OP_ERASE, 13'h1800, 8'h00, 8'h00, seen);
    `CHK(seen, 1'b1)
    op(OP_ERASE, 13'h1A00, 8'h00, 8'h00, seen);
    op(OP_PROG, 13'h19FF, 8'h3C, 8'h00, seen);
    op(OP_PROG, 13'h1A00, 8'h77, 8'h00, seen);
    op(OP_READ, 13'h19FF, 8'h00, 8'h00, seen);
    axr(OFS_DATA, rd, rsp);
    `CHK(rd[7:0], 8'h3C)
    op(OP_ERASE, 13'h1900, 8'h00, 8'h00, seen);
    op(OP_READ, 13'h19FF, 8'h00, 8'h00, seen);
    axr(OFS_DATA, rd, rsp);
    `CHK(rd[7:0], 8'hFF)
    op(OP_READ, 13'h1A00, 8'h00, 8'h00, seen);
    axr(OFS_DATA, rd, rsp);
    `CHK(rd[7:0], 8'h77)
    cr(13'h1A00, 1'b1);
    `CHK(crd, 8'h77)
    axr(OFS_CTRL, rd, rsp);
    `CHK(rd[BIT_CF], 1'b0)
    $display("test flash ops done");
    op(OP_READ, LOWB - 13'h1, 8'h00, 8'h00, seen);
    `CHK(seen, 1'b0)
    axr(OFS_CTRL, rd, rsp);
    `CHK(rd[BIT_CF], 1'b1)
    op(OP_PROG, LDR, 8'h00, 8'h00, seen);
    `CHK(seen, 1'b0)
    in_ldr <= 1'b1;
    op(OP_READ, 13'h0100, 8'h00, 8'h00, seen);
    `CHK(seen, 1'b1)
    op(OP_READ, LDR, 8'h00, 8'h00, seen);
    `CHK(seen, 1'b0)
    in_ldr <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      op(RSV[i], LOWB, 8'h00, 8'h00, seen);
      `CHK(seen, 1'b0)
    end
    op(OP_READ, LOWB, 8'h00, 8'h12, seen);
    `CHK(seen, 1'b0)
    op(OP_READ, LOWB, 8'h00, CMD_FIRST, seen);
    `CHK(seen, 1'b1)
    axw(OFS_CTRL, 32'h00);
    op(OP_READ, LOWB, 8'h00, 8'h00, seen);
    `CHK(seen, 1'b0)
    $display("test refusals done");
    ldr_on <= 1'b1;
    axw(OFS_CTRL, 32'hE0);
    repeat (3) @(posedge clk);
    `CHK(pulses, 1)
    `CHK(bfl, 1'b1)
    axr(OFS_CTRL, rd, rsp);
    `CHK(rd[BIT_SR], 1'b0)
    axw(OFS_CTRL, 32'hA0);
    repeat (3) @(posedge clk);
    `CHK(bfl, 1'b0)
    `CHK(pulses, 2)
    $display("test soft reset done");
    final_report();
  end
endmodule
`default_nettype wire
